/* rtl/gpb_pkg.sv */
// Package: constants, address map and state types of the port bank
package gpb_pkg;

    localparam int NPORT = 7;
    localparam int PW = 8;

    // Bidirectional port indices
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_E = 3'h3;
    localparam logic [2:0] PORT_F = 3'h4;
    localparam logic [2:0] PORT_G = 3'h5;
    localparam logic [2:0] PORT_L = 3'h6;
    // Output-only port index
    localparam logic [2:0] PORT_D = 3'h7;

    // Register select within a port slot: addr[4:2] port, addr[1:0] select
    localparam int AW = 5;
    localparam logic [1:0] SEL_DATA = 2'h0;
    localparam logic [1:0] SEL_CFG = 2'h1;
    localparam logic [1:0] SEL_PIN = 2'h2;

    // Port widths
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_NIBBLE = 8'h0F;
    localparam logic [7:0] MASK_G_DATA_READ = 8'h3F;

    // Special port bit positions
    localparam int BIT_HALT = 7;
    localparam int BIT_IDLE = 6;
    localparam int BIT_CLOCK_START_DELAY_ENABLE = 7;
    localparam int BIT_ALT_SK = 6;
    localparam int BIT_EXTERNAL_INTERRUPT_INPUT = 0;
    localparam int BIT_WATCHDOG_OUTPUT = 1;
    localparam int BIT_T1B = 2;
    localparam int BIT_T1A = 3;
    localparam int BIT_SO = 4;
    localparam int BIT_SK = 5;
    localparam int BIT_SI = 6;
    localparam int BIT_CKO = 7;
    localparam int BIT_RDX = 3;
    localparam int BIT_CKX = 1;

    // Reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] PORT_D_RST = 8'hFF;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Clock start-up delay after halt
    localparam int CLK_MHZ = 20;
    localparam int CLK_START_DELAY_US = 10;
    localparam int CLK_DLY_CYC = CLK_START_DELAY_US * CLK_MHZ;
    localparam int DW = 16;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [AW-1:0] addr;
        logic [7:0] wdata;
    } gpb_req_s;

    typedef struct packed {
        logic [NPORT-1:0][PW-1:0] cfg;
        logic [NPORT-1:0][PW-1:0] dat;
        logic [PW-1:0] dport;
        logic [NPORT-1:0][PW-1:0] sync1;
        logic [NPORT-1:0][PW-1:0] sync2;
        logic [NPORT-1:0][PW-1:0] pad_oe;
        logic [NPORT-1:0][PW-1:0] pad_out;
        logic [NPORT-1:0][PW-1:0] pad_pu;
        logic [7:0] rdata;
        logic halt;
        logic idle;
        logic osc_run;
        logic clk_ready;
        logic alt_sk;
        logic clock_start_delay_enable_en;
        logic [DW-1:0] dly_cnt;
    } gpb_state_s;

endpackage

/* rtl/gpb_port_bank.sv */
// Port bank: configuration, data and pin registers, pads and special port bits
module gpb_port_bank
    import gpb_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire gpb_req_s req,
    output logic [7:0] rdata_q,
    input wire logic [NPORT-1:0][PW-1:0] pad_in,
    output logic [NPORT-1:0][PW-1:0] pad_out_q,
    output logic [NPORT-1:0][PW-1:0] pad_oe_q,
    output logic [NPORT-1:0][PW-1:0] pad_pu_q,
    output logic [PW-1:0] port_d_out_q,
    input wire logic watchdog_sel,
    input wire logic watchdog_output,
    input wire logic rc_clock_sel,
    input wire logic main_clock_input,
    input wire logic wake_event,
    output logic halt_q,
    output logic idle_q,
    output logic osc_run_q,
    output logic clk_ready_q,
    output logic alt_shift_clock_phase_q,
    output logic clock_start_delay_enable_q,
    output logic external_interrupt_input_q,
    output logic timer1_capture_input_q,
    output logic timer1_io_q,
    output logic serial_data_in_q,
    output logic serial_shift_clock_q,
    output logic [PW-1:0] wake_inputs_q,
    output logic usart_receive_q,
    output logic usart_clock_q
);

    gpb_state_s s_q;
    gpb_state_s s_d;

    // Implemented bits of a port
    function automatic logic [7:0] port_mask(input logic [2:0] p);
        port_mask = (p == PORT_F) ? MASK_NIBBLE : MASK_FULL;
    endfunction

    // Pad set-up from configuration and data bit: {oe, out, pu}
    function automatic logic [2:0] pad_setup(input logic c, input logic d);
        pad_setup = {c, c & d, ~c & d};
    endfunction

    logic [2:0] p_sel;
    logic [1:0] r_sel;
    assign p_sel = req.addr[4:2];
    assign r_sel = req.addr[1:0];

    always_comb begin
        logic [2:0] ps;
        ps = 3'h0;
        s_d = s_q;
        // Two-stage pad synchroniser
        s_d.sync1 = pad_in;
        s_d.sync2 = s_q.sync1;

        // Wake from halt or idle; a start delay may hold the core clock
        if (wake_event && (s_q.halt || s_q.idle)) begin
            s_d.idle = 1'b0;
            if (s_q.halt) begin
                s_d.halt = 1'b0;
                s_d.osc_run = 1'b1;
                if (s_q.clock_start_delay_enable_en) begin
                    s_d.dly_cnt = DW'(CLK_DLY_CYC);
                end else begin
                    s_d.clk_ready = 1'b1;
                end
            end
        end
        if (s_q.dly_cnt != '0) begin
            s_d.dly_cnt = s_q.dly_cnt - DW'(1);
            if (s_q.dly_cnt == DW'(1)) begin
                s_d.clk_ready = 1'b1;
            end
        end

        // Register writes; entry to a power-save mode wins over a wake
        if (req.wr) begin
            if (p_sel == PORT_D) begin
                if (r_sel == SEL_DATA) begin
                    s_d.dport = req.wdata;
                end
            end else if (r_sel == SEL_DATA) begin
                s_d.dat[p_sel] = req.wdata & port_mask(p_sel);
                if (p_sel == PORT_G && req.wdata[BIT_HALT]) begin
                    s_d.halt = 1'b1;
                    s_d.osc_run = 1'b0;
                    s_d.clk_ready = 1'b0;
                    s_d.dly_cnt = '0;
                end
                if (p_sel == PORT_G && req.wdata[BIT_IDLE]) begin
                    s_d.idle = 1'b1;
                end
            end else if (r_sel == SEL_CFG) begin
                s_d.cfg[p_sel] = req.wdata & port_mask(p_sel);
            end
        end

        // Register reads
        if (req.rd) begin
            s_d.rdata = RDATA_RST;
            if (p_sel == PORT_D) begin
                if (r_sel == SEL_DATA) begin
                    s_d.rdata = s_q.dport;
                end
            end else begin
                case (r_sel)
                    SEL_DATA: begin
                        if (p_sel == PORT_G) begin
                            s_d.rdata = s_q.dat[p_sel] & MASK_G_DATA_READ;
                        end else begin
                            s_d.rdata = s_q.dat[p_sel];
                        end
                    end
                    SEL_CFG: s_d.rdata = s_q.cfg[p_sel];
                    SEL_PIN: s_d.rdata = s_q.sync2[p_sel] & port_mask(p_sel);
                    default: s_d.rdata = RDATA_RST;
                endcase
            end
        end

        // Pad drive for every implemented bit
        for (int p = 0; p < NPORT; p++) begin
            ps = 3'(p);
            for (int b = 0; b < PW; b++) begin
                if (port_mask(ps)[b]) begin
                    {s_d.pad_oe[p][b], s_d.pad_out[p][b], s_d.pad_pu[p][b]} =
                        pad_setup(s_d.cfg[p][b], s_d.dat[p][b]);
                end else begin
                    {s_d.pad_oe[p][b], s_d.pad_out[p][b], s_d.pad_pu[p][b]} = 3'h0;
                end
            end
        end

        // Special port pin overrides
        s_d.pad_oe[PORT_G][BIT_SI] = 1'b0;
        s_d.pad_out[PORT_G][BIT_SI] = 1'b0;
        s_d.pad_pu[PORT_G][BIT_SI] = 1'b0;
        s_d.pad_oe[PORT_G][BIT_CKO] = 1'b1;
        s_d.pad_out[PORT_G][BIT_CKO] = main_clock_input & s_d.osc_run;
        s_d.pad_pu[PORT_G][BIT_CKO] = 1'b0;
        if (watchdog_sel) begin
            s_d.pad_oe[PORT_G][BIT_WATCHDOG_OUTPUT] = ~watchdog_output;
            s_d.pad_out[PORT_G][BIT_WATCHDOG_OUTPUT] = 1'b0;
            s_d.pad_pu[PORT_G][BIT_WATCHDOG_OUTPUT] = 1'b1;
        end

        s_d.alt_sk = s_d.cfg[PORT_G][BIT_ALT_SK];
        s_d.clock_start_delay_enable_en = s_d.cfg[PORT_G][BIT_CLOCK_START_DELAY_ENABLE] & rc_clock_sel;

        if (!nrst) begin
            s_d = '0;
            s_d.cfg = {NPORT{CFG_RST}};
            s_d.dat = {NPORT{DATA_RST}};
            s_d.dport = PORT_D_RST;
            s_d.rdata = RDATA_RST;
            s_d.osc_run = 1'b1;
            s_d.clk_ready = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign rdata_q = s_q.rdata;
    assign pad_out_q = s_q.pad_out;
    assign pad_oe_q = s_q.pad_oe;
    assign pad_pu_q = s_q.pad_pu;
    assign port_d_out_q = s_q.dport;
    assign halt_q = s_q.halt;
    assign idle_q = s_q.idle;
    assign osc_run_q = s_q.osc_run;
    assign clk_ready_q = s_q.clk_ready;
    assign alt_shift_clock_phase_q = s_q.alt_sk;
    assign clock_start_delay_enable_q = s_q.clock_start_delay_enable_en;
    // Alternate-function inputs from the synchronised pads
    assign external_interrupt_input_q = s_q.sync2[PORT_G][BIT_EXTERNAL_INTERRUPT_INPUT];
    assign timer1_capture_input_q = s_q.sync2[PORT_G][BIT_T1B];
    assign timer1_io_q = s_q.sync2[PORT_G][BIT_T1A];
    assign serial_data_in_q = s_q.sync2[PORT_G][BIT_SI];
    assign serial_shift_clock_q = s_q.sync2[PORT_G][BIT_SK];
    assign wake_inputs_q = s_q.sync2[PORT_L];
    assign usart_receive_q = s_q.sync2[PORT_L][BIT_RDX];
    assign usart_clock_q = s_q.sync2[PORT_L][BIT_CKX];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence halt_write_s;
        req.wr && p_sel == PORT_G && r_sel == SEL_DATA && req.wdata[BIT_HALT];
    endsequence

    sequence delayed_wake_s;
        halt_q && wake_event && clock_start_delay_enable_q && !req.wr;
    endsequence

    chk_g6_never_drives: assert property (!pad_oe_q[PORT_G][BIT_SI])
        else $error("special bit 6 pad is driven");
    chk_g_data_zero: assert property (req.rd && p_sel == PORT_G && r_sel == SEL_DATA
        |=> rdata_q[7:6] == 2'h0)
        else $error("special data bits 6/7 did not read zero");
    chk_halt_stops_osc: assert property (halt_write_s |=> halt_q && !osc_run_q && !clk_ready_q)
        else $error("halt write did not stop oscillator");
    chk_idle_entry: assert property (req.wr && p_sel == PORT_G && r_sel == SEL_DATA
        && req.wdata[BIT_IDLE] |=> idle_q)
        else $error("idle write did not enter idle");
    chk_alt_sk_follow: assert property (##1 alt_shift_clock_phase_q == s_q.cfg[PORT_G][BIT_ALT_SK])
        else $error("alternate shift phase not following config");
    chk_pad_decode: assert property (pad_oe_q[PORT_A] == s_q.cfg[PORT_A]
        && pad_pu_q[PORT_A] == (~s_q.cfg[PORT_A] & s_q.dat[PORT_A])
        && pad_out_q[PORT_A] == (s_q.cfg[PORT_A] & s_q.dat[PORT_A]))
        else $error("pad set-up decode wrong");
    chk_pin_read: assert property (req.rd && p_sel == PORT_B && r_sel == SEL_PIN
        |=> rdata_q == $past(s_q.sync2[PORT_B]))
        else $error("pin register not pad level");
    chk_watchdog_output_pullup: assert property (watchdog_sel |=> pad_pu_q[PORT_G][BIT_WATCHDOG_OUTPUT]
        && !pad_out_q[PORT_G][BIT_WATCHDOG_OUTPUT])
        else $error("watchdog pin lacks pull-up");
    chk_start_delay: assert property (delayed_wake_s |=> osc_run_q && !clk_ready_q [*8])
        else $error("clock start delay not applied");
    chk_port_d_reset: assert property (disable iff (1'b0) !nrst |=> port_d_out_q == PORT_D_RST)
        else $error("output port not high after reset");

endmodule

/* tb/gpb_board.sv */
// Board model: resolves each pad from drive, pull-up and outside level
module gpb_board
    import gpb_pkg::*;
(
    input wire logic [NPORT-1:0][PW-1:0] oe,
    input wire logic [NPORT-1:0][PW-1:0] out,
    input wire logic [NPORT-1:0][PW-1:0] pu,
    input wire logic [NPORT-1:0][PW-1:0] ext,
    output logic [NPORT-1:0][PW-1:0] pad
);
    timeunit 1ns;
    timeprecision 1ns;
    // Driven pin wins, then pull-up, else board level
    assign pad = (oe & out) | (~oe & pu) | (~oe & ~pu & ext);
endmodule

/* tb/testbench.sv */
// Testbench: register accesses, pad decode and special port functions
module testbench
    import gpb_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    gpb_req_s req = '0;
    logic [7:0] rdata_q, port_d_out_q, wake_inputs_q;
    logic [NPORT-1:0][PW-1:0] pad_in, pad_out_q, pad_oe_q, pad_pu_q;
    logic [NPORT-1:0][PW-1:0] ext = {NPORT{8'hC6}};
    logic watchdog_sel = 1'b0;
    logic watchdog_output = 1'b1;
    logic rc_clock_sel = 1'b0;
    logic main_clock_input = 1'b0;
    logic wake_event = 1'b0;
    logic halt_q, idle_q, osc_run_q, clk_ready_q, alt_shift_clock_phase_q, clock_start_delay_enable_q;
    logic external_interrupt_input_q, timer1_capture_input_q, timer1_io_q, serial_data_in_q;
    logic serial_shift_clock_q, usart_receive_q, usart_clock_q;
    int fails = 0;
    int compares = 0;

    gpb_port_bank dut (.*);
    gpb_board brd (.oe(pad_oe_q), .out(pad_out_q), .pu(pad_pu_q), .ext(ext), .pad(pad_in));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic r, input logic [2:0] p, input logic [1:0] s, input logic [7:0] d);
        @(negedge clk);
        req = '{rd: r, wr: ~r, addr: {p, s}, wdata: d};
        @(negedge clk);
        req = '0;
    endtask

    task automatic wr(input logic [2:0] p, input logic [1:0] s, input logic [7:0] d);
        acc(1'b0, p, s, d);
    endtask

    task automatic rchk(input logic [2:0] p, input logic [1:0] s, input logic [7:0] e);
        acc(1'b1, p, s, 8'h00);
        chk(rdata_q, e);
    endtask

    task automatic wake;
        @(negedge clk);
        wake_event = 1'b1;
        @(negedge clk);
        wake_event = 1'b0;
    endtask

    task automatic summarize;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #250000;
        fails++;
        summarize();
    end

    initial begin
        logic [7:0] m;
        logic [7:0] d;
        repeat (12) @(negedge clk);
        chk(port_d_out_q, 8'hFF);
        chk({4'h0, halt_q, idle_q, osc_run_q, clk_ready_q}, 8'h03);
        nrst = 1'b1;
        // Every bidirectional port: decode, read-back widths and pin levels
        for (int p = 0; p < NPORT; p++) begin
            m = (p == 4) ? MASK_NIBBLE : ((p == 5) ? 8'h3F : MASK_FULL);
            d = 8'h25 + 8'(p);
            wr(3'(p), SEL_CFG, 8'h33);
            wr(3'(p), SEL_DATA, d);
            chk(pad_oe_q[p] & m, 8'h33 & m);
            chk(pad_out_q[p] & pad_oe_q[p] & m, d & 8'h33 & m);
            chk(pad_pu_q[p] & m, d & 8'hCC & m);
            rchk(3'(p), SEL_CFG, 8'h33 & m);
            rchk(3'(p), SEL_DATA, d & m);
            rchk(3'(p), SEL_PIN, (d | (8'hCC & ~d & 8'hC6)) & ((p == 5) ? 8'h7F : m));
        end
        wr(PORT_D, SEL_DATA, 8'h5A);
        chk(port_d_out_q, 8'h5A);
        wr(PORT_D, SEL_CFG, 8'hFF);
        rchk(PORT_D, SEL_CFG, 8'h00);
        wr(PORT_A, 2'h3, 8'hFF);
        rchk(PORT_A, 2'h3, 8'h00);
        wr(PORT_G, SEL_CFG, 8'h40);
        wr(PORT_G, SEL_DATA, 8'h40);
        chk({6'h0, alt_shift_clock_phase_q, idle_q}, 8'h03);
        chk({7'h0, pad_oe_q[PORT_G][6]}, 8'h00);
        rchk(PORT_G, SEL_DATA, 8'h00);
        wake();
        chk({7'h0, idle_q}, 8'h00);
        wr(PORT_G, SEL_DATA, 8'h80);
        chk({5'h0, halt_q, osc_run_q, clk_ready_q}, 8'h04);
        rchk(PORT_G, SEL_DATA, 8'h00);
        wake();
        chk({5'h0, halt_q, osc_run_q, clk_ready_q}, 8'h03);
        // Start delay only with the R/C option and the delay bit
        rc_clock_sel = 1'b1;
        wr(PORT_G, SEL_CFG, 8'h80);
        wr(PORT_G, SEL_DATA, 8'h80);
        wake();
        repeat (CLK_DLY_CYC - 10) @(negedge clk);
        chk({5'h0, clock_start_delay_enable_q, osc_run_q, clk_ready_q}, 8'h06);
        repeat (20) @(negedge clk);
        chk({7'h0, clk_ready_q}, 8'h01);
        wr(PORT_G, SEL_CFG, 8'h02);
        wr(PORT_G, SEL_DATA, 8'h00);
        watchdog_sel = 1'b1;
        watchdog_output = 1'b0;
        repeat (2) @(negedge clk);
        chk({5'h0, pad_oe_q[PORT_G][1], pad_out_q[PORT_G][1], pad_pu_q[PORT_G][1]}, 8'h05);
        watchdog_output = 1'b1;
        repeat (2) @(negedge clk);
        chk({6'h0, pad_oe_q[PORT_G][1], pad_pu_q[PORT_G][1]}, 8'h01);
        main_clock_input = 1'b1;
        repeat (2) @(negedge clk);
        chk({6'h0, pad_oe_q[PORT_G][7], pad_out_q[PORT_G][7]}, 8'h03);
        watchdog_sel = 1'b0;
        ext[PORT_G] = 8'h65;
        ext[PORT_L] = 8'hA6;
        wr(PORT_L, SEL_CFG, 8'h00);
        wr(PORT_L, SEL_DATA, 8'h00);
        repeat (3) @(negedge clk);
        chk({3'h0, external_interrupt_input_q, timer1_capture_input_q, timer1_io_q,
            serial_data_in_q, serial_shift_clock_q}, 8'h1B);
        chk(wake_inputs_q, 8'hA6);
        chk({6'h0, usart_receive_q, usart_clock_q}, 8'h01);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        chk(port_d_out_q, 8'hFF);
        nrst = 1'b1;
        summarize();
    end
endmodule
